/* core/csfac_pkg.sv */
package csfac_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int SEQ_MAX = 6;
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam int MSB = BYTE_W - 1;
  localparam logic [7:0] CCR_FIXED = 8'h60;
  localparam logic [7:0] CCR_RESET = 8'h68;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DIRECT_PAGE_HIGH = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_RET = 3'h2;
  localparam logic [2:0] LEN_ALL = 3'h6;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LOAD = 5'h01, OP_ADD = 5'h02, OP_ADC = 5'h03,
    OP_SUB = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_EOR = 5'h07,
    OP_PUSH_ACC = 5'h08, OP_PULL_ACC = 5'h09, OP_CALL = 5'h0a,
    OP_RETURN = 5'h0b, OP_RETURN_INT = 5'h0c, OP_BRANCH = 5'h0d,
    OP_EA_DIRECT = 5'h0e, OP_EA_SP8 = 5'h0f, OP_EA_SP16 = 5'h10,
    OP_FETCH = 5'h11, OP_LOAD_INDEX = 5'h12, OP_LOAD_SP = 5'h13,
    OP_SET_MASK = 5'h14, OP_CLEAR_MASK = 5'h15
  } csfac_op_t;

  typedef enum logic [2:0] {
    ALU_NONE = 3'h0, ALU_PASS = 3'h1, ALU_ADD = 3'h2, ALU_ADC = 3'h3,
    ALU_SUB = 3'h4, ALU_AND = 3'h5, ALU_OR = 3'h6, ALU_EOR = 3'h7
  } csfac_alu_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PUSH = 4'b0010,
    ST_PULL = 4'b0100,
    ST_FETCH = 4'b1000
  } csfac_state_t;
endpackage

/* core/csfac_alu_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface csfac_alu_if;
  import csfac_pkg::*;
  csfac_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic c_in;
  logic [7:0] result;
  logic n;
  logic z;
  logic v;
  logic h;
  logic c;
  modport core (output op, output a, output b, output c_in,
                input result, input n, input z, input v, input h, input c);
  modport alu (input op, input a, input b, input c_in,
               output result, output n, output z, output v, output h, output c);
endinterface
`default_nettype wire

/* core/csfac_alu.sv */
`timescale 1ns/10ps
`default_nettype none
module csfac_alu
  import csfac_pkg::*;
(
  csfac_alu_if.alu bus
);
  wire logic cin_eff = (bus.op == ALU_ADC) ? bus.c_in : 1'b0;
  wire logic [8:0] add_w = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin_eff};
  wire logic [8:0] sub_w = {1'b0, bus.a} - {1'b0, bus.b};
  wire logic [4:0] nib_w = {1'b0, bus.a[NIB_W-1:0]} + {1'b0, bus.b[NIB_W-1:0]} + {4'h0, cin_eff};
  wire logic is_add = (bus.op == ALU_ADD) || (bus.op == ALU_ADC);
  wire logic is_sub = (bus.op == ALU_SUB);

  assign bus.result = is_add ? add_w[MSB:0] :
                      is_sub ? sub_w[MSB:0] :
                      (bus.op == ALU_AND) ? (bus.a & bus.b) :
                      (bus.op == ALU_OR) ? (bus.a | bus.b) :
                      (bus.op == ALU_EOR) ? (bus.a ^ bus.b) : bus.b;
  assign bus.n = bus.result[MSB];
  assign bus.z = (bus.result == BYTE_ZERO);
  assign bus.h = nib_w[NIB_W];
  assign bus.c = is_add ? add_w[BYTE_W] : sub_w[BYTE_W];
  // Overflow is only meaningful for add and subtract; logic and loads clear it.
  assign bus.v = is_add ? ((bus.a[MSB] == bus.b[MSB]) && (bus.result[MSB] != bus.a[MSB])) :
                 is_sub ? ((bus.a[MSB] != bus.b[MSB]) && (bus.result[MSB] != bus.a[MSB])) :
                 1'b0;
endmodule
`default_nettype wire

/* core/csfac_core.sv */
`timescale 1ns/10ps
`default_nettype none
module csfac_core
  import csfac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire csfac_op_t cmd_op,
  input wire logic [7:0] cmd_byte,
  input wire logic [15:0] cmd_word,
  input wire logic branch_cond,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [7:0] mem_rdata,
  output logic cmd_ready,
  output logic irq_taken,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic [15:0] eff_addr,
  output logic [7:0] fetch_data,
  output logic [7:0] accumulator_reg,
  output logic [15:0] index_pair,
  output logic [15:0] stack_ptr,
  output logic [15:0] program_counter,
  output logic [7:0] condition_code_reg
);
  function automatic csfac_alu_op_t f_alu_of(input csfac_op_t op);
    unique case (op)
      OP_LOAD: f_alu_of = ALU_PASS;
      OP_ADD: f_alu_of = ALU_ADD;
      OP_ADC: f_alu_of = ALU_ADC;
      OP_SUB: f_alu_of = ALU_SUB;
      OP_AND: f_alu_of = ALU_AND;
      OP_OR: f_alu_of = ALU_OR;
      OP_EOR: f_alu_of = ALU_EOR;
      default: f_alu_of = ALU_NONE;
    endcase
  endfunction

  csfac_state_t state_q;
  csfac_op_t kind_q;
  logic [7:0] acc_q;
  logic [15:0] idx_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] ccr_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic we_q;
  logic re_q;
  logic [15:0] ea_q;
  logic [7:0] fetch_q;
  logic irq_taken_q;
  logic [2:0] len_q;
  logic [2:0] iss_q;
  logic [2:0] cap_q;
  logic [7:0] push_buf_q [SEQ_MAX];
  logic [7:0] pull_buf_q [SEQ_MAX];
  logic [7:0] push_list_w [SEQ_MAX];
  logic [2:0] push_len_w;
  logic [7:0] ccr_alu_w;

  csfac_alu_if alu_bus ();
  csfac_alu u_alu (.bus(alu_bus));

  wire logic idle = (state_q == ST_IDLE);
  // A pending unmasked request takes the idle slot ahead of any command.
  wire logic irq_take = idle && irq_req && !ccr_q[CCR_I];
  wire logic cmd_take = idle && !irq_take && cmd_valid;
  wire csfac_alu_op_t alu_sel = f_alu_of(cmd_op);
  wire logic is_alu = (alu_sel != ALU_NONE);
  wire logic is_addlike = (alu_sel == ALU_ADD) || (alu_sel == ALU_ADC);
  wire logic is_arith = is_addlike || (alu_sel == ALU_SUB);
  wire logic [15:0] branch_off = {{BYTE_W{cmd_byte[MSB]}}, cmd_byte};
  wire logic [15:0] sp_inc = sp_q + WORD_ONE;
  wire logic [15:0] sp_dec = sp_q - WORD_ONE;
  wire logic issue_more = (iss_q != len_q);
  wire logic pull_done = (cap_q == len_q);

  assign alu_bus.op = alu_sel;
  assign alu_bus.a = acc_q;
  assign alu_bus.b = cmd_byte;
  assign alu_bus.c_in = ccr_q[CCR_C];

  always_comb begin
    ccr_alu_w = ccr_q;
    ccr_alu_w[CCR_N] = alu_bus.n;
    ccr_alu_w[CCR_Z] = alu_bus.z;
    ccr_alu_w[CCR_V] = alu_bus.v;
    if (is_addlike) begin
      ccr_alu_w[CCR_H] = alu_bus.h;
    end
    if (is_arith) begin
      ccr_alu_w[CCR_C] = alu_bus.c;
    end
  end

  // Bytes are listed in the order they are written, first at the highest address, last at the top of the stack.
  always_comb begin
    for (int i = 0; i < SEQ_MAX; i++) begin
      push_list_w[i] = BYTE_ZERO;
    end
    push_len_w = 3'h0;
    if (irq_take) begin
      push_list_w[0] = pc_q[BYTE_W-1:0];
      push_list_w[1] = pc_q[WORD_W-1:BYTE_W];
      push_list_w[2] = idx_q[BYTE_W-1:0];
      push_list_w[3] = idx_q[WORD_W-1:BYTE_W];
      push_list_w[4] = acc_q;
      push_list_w[5] = ccr_q;
      push_len_w = LEN_ALL;
    end else if (cmd_op == OP_CALL) begin
      push_list_w[0] = pc_q[BYTE_W-1:0];
      push_list_w[1] = pc_q[WORD_W-1:BYTE_W];
      push_len_w = LEN_RET;
    end else begin
      push_list_w[0] = acc_q;
      push_len_w = LEN_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      kind_q <= OP_NOP;
      acc_q <= BYTE_ZERO;
      idx_q <= 16'h0000;
      sp_q <= SP_RESET;
      pc_q <= PC_RESET;
      ccr_q <= CCR_RESET;
      addr_q <= 16'h0000;
      wdata_q <= BYTE_ZERO;
      we_q <= 1'b0;
      re_q <= 1'b0;
      ea_q <= 16'h0000;
      fetch_q <= BYTE_ZERO;
      irq_taken_q <= 1'b0;
      len_q <= 3'h0;
      iss_q <= 3'h0;
      cap_q <= 3'h0;
      for (int i = 0; i < SEQ_MAX; i++) begin
        push_buf_q[i] <= BYTE_ZERO;
        pull_buf_q[i] <= BYTE_ZERO;
      end
    end else if (ce) begin
      irq_taken_q <= irq_take;
      unique case (state_q)
        ST_IDLE: begin
          we_q <= 1'b0;
          re_q <= 1'b0;
          iss_q <= 3'h0;
          cap_q <= 3'h0;
          if (irq_take || (cmd_take && (cmd_op == OP_CALL || cmd_op == OP_PUSH_ACC))) begin
            for (int i = 0; i < SEQ_MAX; i++) begin
              push_buf_q[i] <= push_list_w[i];
            end
            len_q <= push_len_w;
            state_q <= ST_PUSH;
            if (irq_take) begin
              ccr_q[CCR_I] <= 1'b1;
              pc_q <= irq_vector;
            end else if (cmd_op == OP_CALL) begin
              pc_q <= cmd_word;
            end
          end else if (cmd_take) begin
            kind_q <= cmd_op;
            if (is_alu) begin
              acc_q <= alu_bus.result;
              ccr_q <= ccr_alu_w;
            end
            unique case (cmd_op)
              OP_PULL_ACC: begin
                len_q <= LEN_ONE;
                state_q <= ST_PULL;
              end
              OP_RETURN: begin
                len_q <= LEN_RET;
                state_q <= ST_PULL;
              end
              OP_RETURN_INT: begin
                len_q <= LEN_ALL;
                state_q <= ST_PULL;
              end
              OP_BRANCH: begin
                if (branch_cond) begin
                  pc_q <= pc_q + branch_off;
                end
              end
              OP_EA_DIRECT: ea_q <= {DIRECT_PAGE_HIGH, cmd_byte};
              OP_EA_SP8: ea_q <= sp_q + {BYTE_ZERO, cmd_byte};
              OP_EA_SP16: ea_q <= sp_q + cmd_word;
              OP_FETCH: begin
                addr_q <= pc_q;
                re_q <= 1'b1;
                pc_q <= pc_q + WORD_ONE;
                state_q <= ST_FETCH;
              end
              OP_LOAD_INDEX: idx_q <= cmd_word;
              OP_LOAD_SP: sp_q <= cmd_word;
              OP_SET_MASK: ccr_q[CCR_I] <= 1'b1;
              OP_CLEAR_MASK: ccr_q[CCR_I] <= 1'b0;
              default: begin
              end
            endcase
          end
        end
        ST_PUSH: begin
          if (issue_more) begin
            addr_q <= sp_q;
            wdata_q <= push_buf_q[iss_q];
            we_q <= 1'b1;
            sp_q <= sp_dec;
            iss_q <= iss_q + LEN_ONE;
          end else begin
            we_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_PULL: begin
          if (issue_more) begin
            sp_q <= sp_inc;
            addr_q <= sp_inc;
            re_q <= 1'b1;
            iss_q <= iss_q + LEN_ONE;
          end else begin
            re_q <= 1'b0;
          end
          if (re_q) begin
            pull_buf_q[cap_q] <= mem_rdata;
            cap_q <= cap_q + LEN_ONE;
          end
          if (pull_done) begin
            state_q <= ST_IDLE;
            if (kind_q == OP_RETURN) begin
              pc_q <= {pull_buf_q[0], pull_buf_q[1]};
            end else if (kind_q == OP_RETURN_INT) begin
              ccr_q <= pull_buf_q[0] | CCR_FIXED;
              acc_q <= pull_buf_q[1];
              idx_q <= {pull_buf_q[2], pull_buf_q[3]};
              pc_q <= {pull_buf_q[4], pull_buf_q[5]};
            end else begin
              acc_q <= pull_buf_q[0];
            end
          end
        end
        ST_FETCH: begin
          re_q <= 1'b0;
          fetch_q <= mem_rdata;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign cmd_ready = idle && !irq_take;
  assign irq_taken = irq_taken_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign mem_we = we_q;
  assign mem_re = re_q;
  assign eff_addr = ea_q;
  assign fetch_data = fetch_q;
  assign accumulator_reg = acc_q;
  assign index_pair = idx_q;
  assign stack_ptr = sp_q;
  assign program_counter = pc_q;
  assign condition_code_reg = ccr_q;
endmodule
`default_nettype wire

/* verification/csfac_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module csfac_mem (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] last_q = 8'h00;
  // Outside a read the data lines toggle, so a core sampling late sees junk.
  assign mem_rdata = mem_re ? m[mem_addr] : ~last_q;
  always @(posedge clk) begin
    last_q <= mem_re ? m[mem_addr] : ~last_q;
    if (mem_we) m[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

/* verification/csfac_props.sv */
`timescale 1ns/10ps
`default_nettype none
module csfac_props
  import csfac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire csfac_op_t cmd_op,
  input wire logic [7:0] cmd_byte,
  input wire logic branch_cond,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic cmd_ready,
  input wire logic irq_taken,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] eff_addr,
  input wire logic [7:0] accumulator_reg,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] condition_code_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire tk = ce && cmd_valid && cmd_ready;
  wire alu = tk && cmd_op inside {OP_LOAD, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR};
  // Return address leaves low byte first, the second byte one address lower.
  // The strobes are registered, so the first write is seen two edges after the take.
  sequence s_call;
    mem_we && mem_addr == $past(stack_ptr, 2) && mem_wdata == $past(program_counter[7:0], 2)
    ##1 mem_we && mem_addr == $past(stack_ptr, 3) - WORD_ONE
    && mem_wdata == $past(program_counter[15:8], 3);
  endsequence
  sequence s_stack6;
    mem_we [*6];
  endsequence
  chk_neg_flag:
  assert property (alu |=> condition_code_reg[CCR_N] == accumulator_reg[MSB])
    else $error("negative flag wrong");
  chk_zero_flag:
  assert property (alu |=> condition_code_reg[CCR_Z] == (accumulator_reg == BYTE_ZERO))
    else $error("zero flag wrong");
  chk_pull_addr:
  assert property (tk && cmd_op == OP_PULL_ACC |-> ##2 mem_re
    && mem_addr == $past(stack_ptr, 2) + WORD_ONE)
    else $error("pull address wrong");
  chk_push_order:
  assert property (tk && cmd_op == OP_PUSH_ACC |-> ##2 mem_we && mem_addr == $past(stack_ptr, 2)
    && mem_wdata == $past(accumulator_reg, 2) && stack_ptr == $past(stack_ptr, 2) - WORD_ONE)
    else $error("push wrong");
  chk_call_stack:
  assert property (tk && cmd_op == OP_CALL |-> ##2 s_call)
    else $error("call stacking wrong");
  chk_irq_entry:
  assert property (irq_taken |-> program_counter == $past(irq_vector)
    && condition_code_reg[CCR_I] ##1 s_stack6)
    else $error("interrupt entry wrong");
  chk_branch_dest:
  assert property (tk && cmd_op == OP_BRANCH |=> program_counter == $past(program_counter)
    + ($past(branch_cond) ? {{8{$past(cmd_byte[7])}}, $past(cmd_byte)} : 16'h0000))
    else $error("branch target wrong");
  chk_sp_offset:
  assert property (tk && cmd_op == OP_EA_SP8 |=> eff_addr == $past(stack_ptr)
    + {8'h00, $past(cmd_byte)})
    else $error("stack offset address wrong");
  chk_fetch_next:
  assert property (tk && cmd_op == OP_FETCH |=> mem_re && mem_addr == $past(program_counter)
    && program_counter == $past(program_counter) + WORD_ONE)
    else $error("fetch address wrong");
  chk_direct_page:
  assert property (tk && cmd_op == OP_EA_DIRECT |=> eff_addr == {DIRECT_PAGE_HIGH, $past(cmd_byte)})
    else $error("direct address wrong");
  chk_mask_gate:
  assert property (irq_taken |-> $past(irq_req) && !$past(condition_code_reg[CCR_I]))
    else $error("masked interrupt taken");
endmodule
`default_nettype wire

/* verification/csfac_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module csfac_core_bench
  import csfac_pkg::*;
;
  logic clk = 0, reset = 1, ce = 1, cmd_valid = 0, branch_cond = 0, irq_req = 0;
  csfac_op_t cmd_op = OP_NOP;
  logic [7:0] cmd_byte = 8'h00;
  logic [15:0] cmd_word = 16'h0000, irq_vector = 16'h0000;
  logic cmd_ready, irq_taken, mem_we, mem_re;
  logic [15:0] mem_addr, eff_addr, index_pair, stack_ptr, program_counter;
  logic [7:0] mem_wdata, mem_rdata, fetch_data, accumulator_reg, condition_code_reg;
  int error_cnt = 0, n_tests = 0;
  csfac_core DUT (
    .clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_byte(cmd_byte), .cmd_word(cmd_word), .branch_cond(branch_cond), .irq_req(irq_req),
    .irq_vector(irq_vector), .mem_rdata(mem_rdata), .cmd_ready(cmd_ready),
    .irq_taken(irq_taken), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .eff_addr(eff_addr), .fetch_data(fetch_data),
    .accumulator_reg(accumulator_reg), .index_pair(index_pair), .stack_ptr(stack_ptr),
    .program_counter(program_counter), .condition_code_reg(condition_code_reg)
  );
  csfac_mem mem_model (
    .clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata)
  );
  initial forever #50 clk = ~clk;
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic note(string s);
    $display("test %s done", s);
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 40) begin
      chk("ready wait", 0, 1);
      summarize();
    end
  endtask
  task automatic cmd(csfac_op_t op, logic [7:0] b, logic [15:0] w = 16'h0000, logic c = 0);
    wait_ready();
    cmd_op = op;
    cmd_byte = b;
    cmd_word = w;
    branch_cond = c;
    cmd_valid = 1;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 0;
    wait_ready();
    // One idle edge keeps the next request from rising in the step this one fell.
    @(negedge clk);
  endtask
  // ADD, ADC and SUB put carry or borrow in bit 8; other ops pass the old carry.
  function automatic logic [8:0] ref_alu(csfac_op_t op, logic [7:0] a, b, logic c);
    case (op)
      OP_ADD: return a + b;
      OP_ADC: return a + b + c;
      OP_SUB: return a - b;
      OP_AND: return {c, a & b};
      OP_OR: return {c, a | b};
      OP_EOR: return {c, a ^ b};
      default: return {c, b};
    endcase
  endfunction
  initial begin
    static csfac_op_t ops[7] = '{OP_LOAD, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_EOR};
    static logic [7:0] offs[4] = '{8'h7f, 8'h80, 8'h01, 8'hff};
    int i, n;
    logic [8:0] r;
    logic [7:0] b, ea;
    logic ec, hc, vf;
    logic [15:0] ep;
    void'($urandom(32'h29167f29));
    ea = 0;
    ec = 0;
    ep = 0;
    repeat (6) @(negedge clk);
    reset = 0;
    chk("sp", stack_ptr, SP_RESET);
    chk("ccr", condition_code_reg, CCR_RESET);
    for (i = 0; i < 40; i++) begin
      b = (i < 2) ? (i ? 8'h80 : 8'h00) : 8'($urandom);
      r = ref_alu(ops[i % 7], ea, b, ec);
      hc = ({1'b0, ea[3:0]} + b[3:0] + ((ops[i % 7] == OP_ADC) & ec)) > 5'hf;
      // Signed overflow: like signs in giving a different sign out, and the inverse for SUB.
      vf = (ops[i % 7] inside {OP_ADD, OP_ADC}) ? (ea[7] == b[7] && r[7] != ea[7]) :
           (ops[i % 7] == OP_SUB) ? (ea[7] != b[7] && r[7] != ea[7]) : 1'b0;
      cmd(ops[i % 7], b);
      chk("acc", accumulator_reg, r[7:0]);
      chk("n", condition_code_reg[CCR_N], r[7]);
      chk("z", condition_code_reg[CCR_Z], r[7:0] == 8'h00);
      chk("c", condition_code_reg[CCR_C], r[8]);
      chk("v", condition_code_reg[CCR_V], vf);
      if (ops[i % 7] inside {OP_ADD, OP_ADC}) chk("h", condition_code_reg[CCR_H], hc);
      ea = r[7:0];
      ec = r[8];
    end
    note("alu");
    cmd(OP_PUSH_ACC, 0);
    chk("push", mem_model.m[16'h00ff], ea);
    chk("sp", stack_ptr, 16'h00fe);
    cmd(OP_LOAD, ~ea);
    cmd(OP_PULL_ACC, 0);
    chk("pull", accumulator_reg, ea);
    chk("sp", stack_ptr, 16'h00ff);
    // A return address with distinct bytes shows whether they are stacked in order.
    ep = 16'hff80;
    cmd(OP_BRANCH, 8'h80, 0, 1);
    chk("branch", program_counter, ep);
    cmd(OP_CALL, 0, 16'h1234);
    chk("pc", program_counter, 16'h1234);
    chk("lo", mem_model.m[16'h00ff], ep[7:0]);
    chk("hi", mem_model.m[16'h00fe], ep[15:8]);
    cmd(OP_RETURN, 0);
    chk("ret", program_counter, ep);
    chk("sp", stack_ptr, 16'h00ff);
    note("stack");
    for (i = 0; i < 4; i++) begin
      if (i != 2) ep = ep + {{8{offs[i][7]}}, offs[i]};
      cmd(OP_BRANCH, offs[i], 0, i != 2);
      chk("branch", program_counter, ep);
    end
    b = 8'($urandom);
    mem_model.m[ep] = b;
    cmd(OP_FETCH, 0);
    ep = ep + 1;
    chk("fetch", fetch_data, b);
    chk("pc", program_counter, ep);
    cmd(OP_EA_DIRECT, 8'hff);
    chk("direct", eff_addr, 16'h00ff);
    cmd(OP_EA_SP8, 8'hff);
    chk("sp8", eff_addr, 16'h01fe);
    cmd(OP_EA_SP16, 0, 16'hffff);
    chk("sp16", eff_addr, 16'h00fe);
    note("addr");
    ce = 0;
    cmd_op = OP_LOAD;
    cmd_byte = ~ea;
    cmd_valid = 1;
    repeat (3) @(negedge clk);
    chk("frozen", accumulator_reg, ea);
    ce = 1;
    cmd_valid = 0;
    cmd(OP_LOAD_INDEX, 0, 16'hbeef);
    irq_vector = 16'h4000;
    irq_req = 1;
    repeat (4) @(negedge clk);
    chk("masked", irq_taken, 0);
    irq_req = 0;
    cmd(OP_CLEAR_MASK, 0);
    irq_req = 1;
    for (n = 0; n < 20 && irq_taken !== 1'b1; n++) @(negedge clk);
    chk("taken", irq_taken, 1);
    if (n == 20) summarize();
    irq_req = 0;
    chk("vector", program_counter, 16'h4000);
    wait_ready();
    chk("sp", stack_ptr, 16'h00f9);
    chk("pcl", mem_model.m[16'h00ff], ep[7:0]);
    chk("xh", mem_model.m[16'h00fc], 16'h00be);
    chk("a", mem_model.m[16'h00fb], ea);
    cmd(OP_RETURN_INT, 0);
    chk("pc", program_counter, ep);
    chk("x", index_pair, 16'hbeef);
    chk("i", condition_code_reg[CCR_I], 0);
    note("irq");
    summarize();
  end
endmodule
bind csfac_core csfac_props chk_i (
  .clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_byte(cmd_byte), .branch_cond(branch_cond), .irq_req(irq_req), .irq_vector(irq_vector),
  .cmd_ready(cmd_ready), .irq_taken(irq_taken), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_we(mem_we), .mem_re(mem_re), .eff_addr(eff_addr), .accumulator_reg(accumulator_reg),
  .stack_ptr(stack_ptr), .program_counter(program_counter),
  .condition_code_reg(condition_code_reg)
);
`default_nettype wire
